// ===== design/dtp_pkg.sv
// Shared constants and types for the dual 8-bit timer and PWM unit
package dtp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;

  // Register indexes; byte address is four times the index
  localparam logic [15:0] IDX_TIMER_CONTROL     = 16'hfe18;
  localparam logic [15:0] IDX_PRESCALER_SETTING = 16'hfe19;
  localparam logic [15:0] IDX_LOW_COUNT_VALUE   = 16'hfe1a;
  localparam logic [15:0] IDX_HIGH_COUNT_VALUE  = 16'hfe1b;
  localparam logic [15:0] IDX_LOW_MATCH_RELOAD  = 16'hfe1c;
  localparam logic [15:0] IDX_HIGH_MATCH_RELOAD = 16'hfe1d;
  localparam logic [15:0] IDX_CLOCK_SOURCE      = 16'hfe1e;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions in timer_control
  localparam int CTL_HIGH_RUN    = 7;
  localparam int CTL_LOW_RUN     = 6;
  localparam int CTL_CASCADE     = 5;
  localparam int CTL_PWM         = 4;
  localparam int CTL_HIGH_FLAG   = 3;
  localparam int CTL_HIGH_IRQ_EN = 2;
  localparam int CTL_LOW_FLAG    = 1;
  localparam int CTL_LOW_IRQ_EN  = 0;

  // Prescaler nibble: enable at bit 3, ratio at bits 2:0
  localparam int PRE_HIGH_LSB = 4;
  localparam int PRE_LOW_LSB  = 0;
  localparam int PRE_EN_BIT   = 3;

  // Clock source register: bit 0 selects the external event input
  localparam int SRC_EVENT_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and byte constants
  localparam logic [7:0] CONTROL_RST   = 8'h00;
  localparam logic [7:0] PRESCALE_RST  = 8'h00;
  localparam logic [7:0] RELOAD_RST    = 8'h00;
  localparam logic [7:0] SOURCE_RST    = 8'h00;
  localparam logic [7:0] COUNT_RST     = 8'h00;
  localparam logic [7:0] ALL_ONES      = 8'hff;
  localparam logic [7:0] ONE           = 8'h01;

  // Operating modes: number is cascade * 2 + pwm
  typedef enum logic [1:0] {
    MODE_SPLIT_TOGGLE = 2'h0,
    MODE_DUAL_PWM     = 2'h1,
    MODE_CASCADE      = 2'h2,
    MODE_CASCADE_PWM  = 2'h3
  } dtp_mode_t;

endpackage

// ===== design/dtp_timer.sv
// Dual 8-bit timer/PWM unit with an Avalon-MM register slave
//
// Functional notes
// R1: Mode number is cascade times two plus pwm
// R2: Low prescaler input: 2 cycles/events, PWM 1
// R3: Event source counts events, else half-rate ticks
// R4: Software never uses events with PWM set
// R5: Low prescale: off=1, else 2 to 256
// R6: High prescale uses the same encoding
// R7: Low prescaler runs on low run bit
// R8: High prescaler runs on high run bit
// R9: High input: 2cyc, 1cyc, low match, PWM period
// R10: Low counter advances per tick, matches buffer
// R11: Low clears when stopped, on match modes 0,2
// R12: High clears on match except in mode 1
// R13: High counter runs, ticks, matches its buffer
// R14: Mode 0 outputs toggle once per period
// R15: Mode 2 high toggles every 16-bit period
// R16: Mode 1 gives two independent 8-bit PWMs
// R17: Mode 3 low PWM, high toggles per periods
// R18: Output held high while byte stopped
// R19: Output held low when reload is all ones
// R20: One interrupt request per counter period
// R21: Flag set at zero, cleared only by software
// R22: Flag and enable together raise interrupt
// R23: Match buffer tracks reload, loads at zero
// R24: PWM output low on overflow, high on match
// R25: Single-cycle enables, event pin synchronised
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ns

module dtp_timer (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // Avalon-MM slave
  input  wire logic [dtp_pkg::ADDR_W-1:0]  address,
  input  wire logic                        read,
  input  wire logic                        write,
  input  wire logic [dtp_pkg::DATA_W-1:0]  writedata,
  input  wire logic [3:0]                  byteenable,
  output logic      [dtp_pkg::DATA_W-1:0]  readdata,
  output logic                             waitrequest,
  // External event pin
  input  wire logic                        eventIn,
  // Waveforms and interrupt
  output logic                             lowWaveOut,
  output logic                             highWaveOut,
  output logic                             timerIrq
);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus

  logic [7:0]  timerControl;
  logic [7:0]  prescalerSetting;
  logic [7:0]  lowReload;
  logic [7:0]  highReload;
  logic [7:0]  clockSource;
  logic [15:0] cntAll;
  logic [15:0] bufAll;
  logic        wrEn;
  logic [7:0]  wd;
  logic [1:0]  zeroHit;
  logic [dtp_pkg::DATA_W-1:0] next_readdata;

  // Word decode used by both the read and the write paths
  function automatic logic hit(input logic [dtp_pkg::ADDR_W-1:0] a,
                               input logic [15:0] idx);
    hit = (a[dtp_pkg::ADDR_W-1:2] == idx);
  endfunction

  // A write lands only at the edge where waitrequest is seen low
  assign wrEn = write && !waitrequest && byteenable[0];
  assign wd   = writedata[7:0];

  // One wait state: request seen, answer on the next edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waitrequest <= 1'b1;
    end else if ((read || write) && waitrequest) begin
      waitrequest <= 1'b0;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  // Read mux; unmapped words read as zero
  always_comb begin
    next_readdata = '0;
    if (hit(address, dtp_pkg::IDX_TIMER_CONTROL)) begin
      next_readdata[7:0] = timerControl;
    end else if (hit(address, dtp_pkg::IDX_PRESCALER_SETTING)) begin
      next_readdata[7:0] = prescalerSetting;
    end else if (hit(address, dtp_pkg::IDX_LOW_COUNT_VALUE)) begin
      next_readdata[7:0] = cntAll[7:0];
    end else if (hit(address, dtp_pkg::IDX_HIGH_COUNT_VALUE)) begin
      next_readdata[7:0] = cntAll[15:8];
    end else if (hit(address, dtp_pkg::IDX_LOW_MATCH_RELOAD)) begin
      next_readdata[7:0] = lowReload;
    end else if (hit(address, dtp_pkg::IDX_HIGH_MATCH_RELOAD)) begin
      next_readdata[7:0] = highReload;
    end else if (hit(address, dtp_pkg::IDX_CLOCK_SOURCE)) begin
      next_readdata[7:0] = clockSource;
    end
  end

  // Read data captured on the request edge, stands at the answer edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readdata <= '0;
    end else if (read && waitrequest) begin
      readdata <= next_readdata;
    end
  end

  // Control register; a hardware set wins over a software clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timerControl <= dtp_pkg::CONTROL_RST;
    end else begin
      if (wrEn && hit(address, dtp_pkg::IDX_TIMER_CONTROL)) begin
        timerControl <= wd;
      end
      if (zeroHit[1]) begin
        timerControl[dtp_pkg::CTL_HIGH_FLAG] <= 1'b1; // R21
      end
      if (zeroHit[0]) begin
        timerControl[dtp_pkg::CTL_LOW_FLAG] <= 1'b1; // R21
      end
    end
  end

  // Plain software-owned registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prescalerSetting <= dtp_pkg::PRESCALE_RST;
      lowReload        <= dtp_pkg::RELOAD_RST;
      highReload       <= dtp_pkg::RELOAD_RST;
      clockSource      <= dtp_pkg::SOURCE_RST;
    end else if (wrEn) begin
      if (hit(address, dtp_pkg::IDX_PRESCALER_SETTING)) begin
        prescalerSetting <= wd;
      end
      if (hit(address, dtp_pkg::IDX_LOW_MATCH_RELOAD)) begin
        lowReload <= wd;
      end
      if (hit(address, dtp_pkg::IDX_HIGH_MATCH_RELOAD)) begin
        highReload <= wd;
      end
      if (hit(address, dtp_pkg::IDX_CLOCK_SOURCE)) begin
        clockSource <= wd;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode and tick sources

  dtp_pkg::dtp_mode_t mode;
  logic       pwmSel;
  logic       eventSel;
  logic       halfTick;
  logic       evSync1;
  logic       evSync2;
  logic       evPrev;
  logic       eventEdge;
  logic [1:0] run;
  logic [1:0] preIn;
  logic [1:0] preTick;
  logic [1:0] match;
  logic [1:0] wrap;
  logic [1:0] clrOnMatch;
  logic [1:0] pwmOut;
  logic [7:0] reloadOf [2];
  logic [3:0] preOf [2];
  logic [1:0] waveAll;

  assign mode = dtp_pkg::dtp_mode_t'({timerControl[dtp_pkg::CTL_CASCADE],
                                      timerControl[dtp_pkg::CTL_PWM]}); // R1
  assign pwmSel   = timerControl[dtp_pkg::CTL_PWM];
  assign eventSel = clockSource[dtp_pkg::SRC_EVENT_BIT];
  assign run      = {timerControl[dtp_pkg::CTL_HIGH_RUN],
                     timerControl[dtp_pkg::CTL_LOW_RUN]};
  assign reloadOf[0] = lowReload;
  assign reloadOf[1] = highReload;
  assign preOf[0] = prescalerSetting[dtp_pkg::PRE_LOW_LSB +: 4];
  assign preOf[1] = prescalerSetting[dtp_pkg::PRE_HIGH_LSB +: 4];

  // Free-running half-rate enable, one cycle high of every two
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      halfTick <= 1'b0;
    end else begin
      halfTick <= !halfTick; // R25
    end
  end

  // Event pin: two-stage synchroniser, then rising-edge detect
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evSync1 <= 1'b0;
      evSync2 <= 1'b0;
      evPrev  <= 1'b0;
    end else begin
      evSync1 <= eventIn;
      evSync2 <= evSync1;
      evPrev  <= evSync2;
    end
  end
  assign eventEdge = evSync2 && !evPrev; // R25

  // Low input: PWM ignores the event source, which is misuse anyway
  assign preIn[0] = pwmSel ? 1'b1 // R2 R4
                  : (eventSel ? eventEdge : halfTick); // R3

  // High input depends on the mode; one driver style for both bits
  assign preIn[1] = (mode == dtp_pkg::MODE_SPLIT_TOGGLE) ? halfTick // R9
                  : (mode == dtp_pkg::MODE_DUAL_PWM) ? 1'b1         // R9
                  : (mode == dtp_pkg::MODE_CASCADE) ? match[0]      // R15
                  : wrap[0];                                        // R17

  // Only mode 1 lets the high byte free-run; low clears only without PWM
  assign clrOnMatch[0] = !pwmSel; // R11
  assign clrOnMatch[1] = (mode != dtp_pkg::MODE_DUAL_PWM); // R12
  assign pwmOut[0]     = pwmSel; // R16 R17
  assign pwmOut[1]     = (mode == dtp_pkg::MODE_DUAL_PWM); // R16

  // Prescaler terminal count: off gives 1, else 2 to 256
  function automatic logic [7:0] preTerm(input logic [3:0] s);
    logic [8:0] ratio;
    ratio = 9'h002 << s[2:0];
    preTerm = s[dtp_pkg::PRE_EN_BIT] ? 8'(ratio - 9'h001) : 8'h00;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Per-byte prescaler, counter, match buffer and waveform

  for (genvar i = 0; i < 2; i++) begin : g_byte
    logic [7:0] preCnt;
    logic [3:0] preAct;
    logic [7:0] cnt;
    logic [7:0] matchBuf;
    logic       wave;

    assign preTick[i] = run[i] && preIn[i]
                     && (preCnt == preTerm(preAct)); // R5 R6
    assign match[i]   = preTick[i] && (cnt == matchBuf); // R10 R13
    assign wrap[i]    = preTick[i] && (cnt == dtp_pkg::ALL_ONES);
    assign zeroHit[i] = wrap[i] || (match[i] && clrOnMatch[i]); // R20
    assign cntAll[8*i +: 8] = cnt;
    assign bufAll[8*i +: 8] = matchBuf;
    assign waveAll[i] = wave;

    // Prescaler cleared when stopped or when its counter resets
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        preCnt <= dtp_pkg::COUNT_RST;
      end else if (!run[i] || zeroHit[i]) begin
        preCnt <= dtp_pkg::COUNT_RST; // R7 R8
      end else if (preIn[i]) begin
        preCnt <= (preCnt == preTerm(preAct)) ? dtp_pkg::COUNT_RST
                : preCnt + dtp_pkg::ONE;
      end
    end

    // Ratio change takes effect with the match buffer reload
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        preAct <= dtp_pkg::PRESCALE_RST[3:0];
      end else if (!run[i] || zeroHit[i]) begin
        preAct <= preOf[i];
      end
    end

    // Counter: zero while stopped, clear on match where the mode says
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        cnt <= dtp_pkg::COUNT_RST;
      end else if (!run[i]) begin
        cnt <= dtp_pkg::COUNT_RST; // R11 R12
      end else if (match[i] && clrOnMatch[i]) begin
        cnt <= dtp_pkg::COUNT_RST; // R11 R12
      end else if (preTick[i]) begin
        cnt <= cnt + dtp_pkg::ONE; // R10 R13
      end
    end

    // Match buffer follows reload when stopped, reloads at zero
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        matchBuf <= dtp_pkg::RELOAD_RST;
      end else if (!run[i] || zeroHit[i]) begin
        matchBuf <= reloadOf[i]; // R23
      end
    end

    // Waveform: stop high, all-ones reload low, then PWM or toggle
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        wave <= 1'b1;
      end else if (!run[i]) begin
        wave <= 1'b1; // R18
      end else if (reloadOf[i] == dtp_pkg::ALL_ONES) begin
        wave <= 1'b0; // R19
      end else if (pwmOut[i]) begin
        if (match[i]) begin
          wave <= 1'b1; // R24
        end else if (wrap[i]) begin
          wave <= 1'b0; // R24
        end
      end else if (match[i]) begin
        wave <= !wave; // R14 R15 R17
      end
    end
  end

  assign lowWaveOut  = waveAll[0];
  assign highWaveOut = waveAll[1];

  // Shared interrupt line, registered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timerIrq <= 1'b0;
    end else begin
      timerIrq <= (timerControl[dtp_pkg::CTL_LOW_FLAG]
                   && timerControl[dtp_pkg::CTL_LOW_IRQ_EN])
               || (timerControl[dtp_pkg::CTL_HIGH_FLAG]
                   && timerControl[dtp_pkg::CTL_HIGH_IRQ_EN]); // R22
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions and covers

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_stop_wave_high: assert property ( // R18
    !run[0] |=> lowWaveOut)
    else $error("low wave not high while stopped");

  a_ones_wave_low: assert property ( // R19
    run[1] && highReload == 8'hff && $stable(run[1]) |=> !highWaveOut)
    else $error("high wave not low with all-ones reload");

  a_stop_count_zero: assert property ( // R11
    !run[0] |=> cntAll[7:0] == 8'h00)
    else $error("low count not zero while stopped");

  a_match_clear_low: assert property ( // R11
    run[0] && !pwmSel && match[0] ##1 run[0] |-> cntAll[7:0] == 8'h00)
    else $error("low count not cleared on match");

  a_free_run_high: assert property ( // R12
    mode == dtp_pkg::MODE_DUAL_PWM && preTick[1] && run[1]
    ##1 run[1] |-> cntAll[15:8] == $past(cntAll[15:8]) + 8'h01)
    else $error("high count did not advance in mode 1");

  a_flag_sticky: assert property ( // R21
    zeroHit[0] |=> timerControl[dtp_pkg::CTL_LOW_FLAG])
    else $error("low flag not set");
  a_flag_held: assert property ( // R21
    timerControl[1] && !(wrEn && hit(address, dtp_pkg::IDX_TIMER_CONTROL))
    |=> timerControl[1])
    else $error("low flag dropped without a write");

  a_irq_follows: assert property ( // R22
    timerControl[3] && timerControl[2] |=> timerIrq)
    else $error("interrupt missing for high flag");

  a_buf_tracks: assert property ( // R23
    !run[1] |=> bufAll[15:8] == $past(highReload))
    else $error("high buffer not tracking reload");

  a_half_rate: assert property ( // R2
    !pwmSel && !eventSel && preIn[0] ##1 !pwmSel && !eventSel
    |-> !preIn[0])
    else $error("low input faster than two cycles");

  a_cascade_tick: assert property ( // R9
    mode == dtp_pkg::MODE_CASCADE && run[1] && !match[0]
    |=> cntAll[15:8] == $past(cntAll[15:8]))
    else $error("high count moved without low match");

  a_bus_answer: assert property (
    (read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer late");

  c_low_pwm_rise: cover property (
    pwmSel && run[0] ##1 $rose(lowWaveOut));
  c_cascade_match: cover property (
    mode == dtp_pkg::MODE_CASCADE && match[1]);
  c_irq_raise: cover property ($rose(timerIrq));

endmodule

// ===== verif/tb_dual_8bit_timer_pwm_unit.sv
// Self-checking bench for the dual 8-bit timer and PWM unit
`timescale 1ns/1ns

module tb_dual_8bit_timer_pwm_unit;

  ////////////////////////////////////////////////////////////////////////////
  // Bench signals
  logic        clk         = 1'b0;
  logic        rst         = 1'b1;
  logic [17:0] address     = 18'h0;
  logic        read        = 1'b0;
  logic        write       = 1'b0;
  logic [31:0] writedata   = 32'h0;
  logic [3:0]  byteenable  = 4'hf;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        eventIn     = 1'b0;
  logic        lowWaveOut;
  logic        highWaveOut;
  logic        timerIrq;
  int          bad_count   = 0;
  int          checks      = 0;

  // Short aliases for the register indexes
  localparam logic [15:0] CTL  = dtp_pkg::IDX_TIMER_CONTROL;
  localparam logic [15:0] PRE  = dtp_pkg::IDX_PRESCALER_SETTING;
  localparam logic [15:0] LCNT = dtp_pkg::IDX_LOW_COUNT_VALUE;
  localparam logic [15:0] LREL = dtp_pkg::IDX_LOW_MATCH_RELOAD;
  localparam logic [15:0] HREL = dtp_pkg::IDX_HIGH_MATCH_RELOAD;
  localparam logic [15:0] SRC  = dtp_pkg::IDX_CLOCK_SOURCE;

  // 100 ns cycle clock
  always #50 clk = ~clk;

  dtp_timer DUT (
    .clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .eventIn(eventIn),
    .lowWaveOut(lowWaveOut), .highWaveOut(highWaveOut),
    .timerIrq(timerIrq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic chk(input logic [31:0] got, exp, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One Avalon access; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [15:0] idx,
                     input logic [7:0] wd, input logic [3:0] be,
                     output logic [31:0] rd);
    @(posedge clk);
    address    <= {idx, 2'b00};
    writedata  <= {24'h0, wd};
    byteenable <= be;
    write      <= wr;
    read       <= !wr;
    // Sampled at the rising edge; only the watchdog ends this wait
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    rd = readdata;
    write <= 1'b0;
    read  <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, idx, d, 4'h1, r);
  endtask

  // Upper bits must read back as zero too
  task automatic rdchk(input logic [15:0] idx, input logic [7:0] e);
    logic [31:0] r;
    bus(1'b0, idx, 8'h0, 4'hf, r);
    chk(r, {24'h0, e}, "readback");
  endtask

  function automatic logic wv(input bit hi);
    return hi ? highWaveOut : lowWaveOut;
  endfunction

  // Skips a partial stretch, then times two whole stretches of a wave
  task automatic gap(input bit hi, output logic l, output int a, b);
    int   n[3];
    logic v;
    for (int k = 0; k < 3; k++) begin
      v = wv(hi);
      if (k == 1) l = v;
      n[k] = 0;
      while (wv(hi) === v && n[k] < 3000) begin
        @(negedge clk);
        n[k]++;
      end
    end
    a = n[1];
    b = n[2];
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    chk(lowWaveOut, 1, "low wave idle");
    chk(highWaveOut, 1, "high wave idle");
    chk(timerIrq, 0, "irq idle");
    for (int i = 0; i < 6; i++) rdchk(CTL + 16'(i), 8'h00);
  endtask

  task automatic t_regs();
    logic [31:0] r;
    wr(PRE, 8'ha5);
    rdchk(PRE, 8'ha5);
    wr(HREL, 8'hc3);
    rdchk(HREL, 8'hc3);
    wr(LCNT, 8'h77);
    rdchk(LCNT, 8'h00);
    bus(1'b1, PRE, 8'h11, 4'he, r);
    rdchk(PRE, 8'ha5);
    bus(1'b1, 16'hfe1f, 8'h55, 4'h1, r);
    rdchk(16'hfe1f, 8'h00);
  endtask

  // Mode 0, low prescale 4, high prescale 2, then a live reload change
  task automatic t_mode0();
    logic l;
    int   a, b;
    wr(PRE, 8'h89);
    wr(LREL, 8'h03);
    wr(HREL, 8'h01);
    wr(CTL, 8'hc0);
    gap(0, l, a, b);
    chk(a, 32, "m0 low");
    chk(b, 32, "m0 low");
    gap(1, l, a, b);
    chk(a, 8, "m0 high");
    chk(b, 8, "m0 high");
    wr(LREL, 8'h07);
    gap(0, l, a, b);
    chk(b, 64, "reload at zero");
    wr(CTL, 8'h00);
    repeat (3) @(negedge clk);
    chk({lowWaveOut, highWaveOut}, 2'b11, "stopped");
    rdchk(LCNT, 8'h00);
  endtask

  // Two PWMs at cycle rate, different duty
  task automatic t_mode1();
    logic l;
    int   a, b;
    wr(PRE, 8'h00);
    wr(LREL, 8'h3f);
    wr(HREL, 8'h1f);
    wr(CTL, 8'hd0);
    gap(0, l, a, b);
    chk(a, l ? 192 : 64, "m1 low");
    chk(b, l ? 64 : 192, "m1 low");
    gap(1, l, a, b);
    chk(a, l ? 224 : 32, "m1 high");
    chk(b, l ? 32 : 224, "m1 high");
    wr(CTL, 8'h00);
  endtask

  task automatic t_mode2();
    logic l;
    int   a, b;
    wr(LREL, 8'h01);
    wr(HREL, 8'h02);
    wr(CTL, 8'he0);
    gap(1, l, a, b);
    chk(a, 12, "m2 high");
    gap(0, l, a, b);
    chk(b, 4, "m2 low");
    wr(CTL, 8'h00);
  endtask

  task automatic t_mode3();
    logic l;
    int   a, b;
    wr(PRE, 8'h80);
    wr(LREL, 8'h3f);
    wr(HREL, 8'h00);
    wr(CTL, 8'hf0);
    gap(1, l, a, b);
    chk(a, 512, "m3 high");
    gap(0, l, a, b);
    chk(a, l ? 192 : 64, "m3 low");
    wr(CTL, 8'h00);
    wr(PRE, 8'h00);
  endtask

  // All-ones reload forces both waves low while running
  task automatic t_full();
    wr(LREL, 8'hff);
    wr(HREL, 8'hff);
    wr(CTL, 8'hc0);
    repeat (6) @(negedge clk);
    chk(lowWaveOut, 0, "ones reload");
    chk(highWaveOut, 0, "ones reload high");
    wr(CTL, 8'h00);
  endtask

  // Flag raise, hold, mask and software clear
  task automatic t_irq();
    int i;
    wr(LREL, 8'h03);
    wr(CTL, 8'h41);
    for (i = 0; i < 40 && timerIrq !== 1'b1; i++) @(negedge clk);
    chk(timerIrq, 1, "irq raised");
    wr(CTL, 8'h03);
    rdchk(CTL, 8'h03);
    repeat (10) @(negedge clk);
    chk(timerIrq, 1, "irq held");
    wr(CTL, 8'h02);
    repeat (3) @(negedge clk);
    chk(timerIrq, 0, "irq masked");
    wr(CTL, 8'h0c);
    repeat (3) @(negedge clk);
    chk(timerIrq, 1, "high irq");
    wr(CTL, 8'h00);
    repeat (3) @(negedge clk);
    chk(timerIrq, 0, "cleared");
  endtask

  // Event counting: clock ignored, two events make one toggle
  task automatic t_event();
    logic v;
    wr(SRC, 8'h01);
    wr(LREL, 8'h01);
    wr(CTL, 8'h40);
    repeat (20) @(negedge clk);
    v = lowWaveOut;
    repeat (30) @(negedge clk);
    chk(lowWaveOut, v, "no events");
    repeat (2) begin
      @(posedge clk);
      eventIn <= 1'b1;
      repeat (5) @(posedge clk);
      eventIn <= 1'b0;
      repeat (5) @(posedge clk);
    end
    repeat (8) @(negedge clk);
    chk(lowWaveOut, !v, "events");
    wr(CTL, 8'h00);
    wr(SRC, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and run control
  task automatic final_report();
    $display("Mismatches %0d in %0d checks", bad_count, checks);
    if (bad_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Whole run needs well under 15000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    chk(0, 1, "watchdog");
    final_report();
  end

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_mode0();
    t_mode1();
    t_mode2();
    t_mode3();
    t_full();
    t_irq();
    t_event();
    final_report();
  end

endmodule
